// ===== hdl/scan_player.v
// Purpose: host scan player that reads the target identification word
// Assumes: single device in chain; tdo sampled from a pin
// Notes:   tck is divided from clk_sys, so it is not a second domain
`timescale 1ns/1ps
`default_nettype none
`include "scan_player_consts.vh"

// Operation
// - instruction load walks to Shift-IR and clocks bits in through tdi.
// - after an instruction, go to Run-Test/Idle and wait there.
// - data scans follow the same walk through the data branch.
// - each scan or wait is produced as tck, tms and tdi sequences.
// - a wait holds the target idle, no scanning, for a duration.
// - instruction scans may pass through Pause-IR on the way to idle.
// - reset the tap, then shift the 10-bit identification-select instruction.
// - wait at least 5 us and 3 tck cycles in idle before data scan.
// - shift 32 ones in while capturing 32 bits of identification from tdo.
// - instruction bits leave least significant array element first.
// - scheme select held at 00 when serial boot shares the board.
// - active-low chain enable held low during scan configuration.
module scan_player #(
   parameter IR_LEN     = `IR_LEN,
   parameter DR_LEN     = `DR_LEN,
   parameter HALF       = `TCK_HALF_CYCLES,
   parameter WAIT_SYS   = `WAIT_SYS_CYCLES,
   parameter IR_PAUSE   = 1
) (
   // clock and reset
   input  wire              clk_sys,
   input  wire              rstn,
   // user command
   input  wire              start,
   output reg               busy_reg,
   output reg               done_reg,
   output reg  [DR_LEN-1:0] id_value_reg,
   // scan pins
   output reg               tck_reg,
   output reg               tms_reg,
   output reg               tdi_reg,
   input  wire              tdo,
   // configuration straps
   output reg  [1:0]        config_scheme_select_reg,
   output reg               chain_enable_n_reg
);

   localparam S_IDLE  = 3'd0;
   localparam S_RST   = 3'd1;
   localparam S_IRSEQ = 3'd2;
   localparam S_WAIT  = 3'd3;
   localparam S_DRSEQ = 3'd4;
   localparam S_DONE  = 3'd5;

   reg [2:0]        phase_reg;
   reg [7:0]        div_reg;
   reg [7:0]        step_reg;     // index into current tms sequence
   reg [15:0]       wait_reg;
   reg [3:0]        tck_wait_reg;
   reg [IR_LEN-1:0] ir_sh_reg;
   reg [DR_LEN-1:0] dr_sh_reg;
   reg              tdo_s1_reg;
   reg              tdo_s2_reg;
   reg              rise;         // comb: rising tck edge this cycle
   reg              fall;
   reg              tms_next;
   reg              last;
   wire [3:0]       tap_state;

   // --------------------------------------------------
   // tdo synchroniser
   // --------------------------------------------------
   always @(posedge clk_sys) begin
      if (!rstn) begin
         tdo_s1_reg <= 1'b0;
         tdo_s2_reg <= 1'b0;
      end else begin
         tdo_s1_reg <= tdo;
         tdo_s2_reg <= tdo_s1_reg;
      end
   end

   // --------------------------------------------------
   // tap mirror
   // --------------------------------------------------
   tap_state_tracker u_tracker (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .step      (rise),
      .tms       (tms_reg),
      .state_reg (tap_state)
   );

   // --------------------------------------------------
   // tms sequence per phase
   // --------------------------------------------------
   always @* begin
      rise     = (div_reg == HALF[7:0] - 8'd1) && !tck_reg && busy_reg && phase_reg != S_DONE;
      fall     = (div_reg == HALF[7:0] - 8'd1) && tck_reg;
      tms_next = 1'b0;
      last     = 1'b0;
      case (phase_reg)
         S_RST: begin
            tms_next = 1'b1;
            last     = (step_reg == `RESET_TMS_EDGES - 1);
         end
         S_IRSEQ: begin
            // idle, drsel, irsel, capture; bits shift on rises 5 to 4+N
            if (step_reg == 8'd1 || step_reg == 8'd2) begin
               tms_next = 1'b1;
            end else if (step_reg == 8'd4 + IR_LEN) begin
               tms_next = 1'b1; // last bit leaves on exit
            end else if (step_reg == 8'd5 + IR_LEN) begin
               tms_next = IR_PAUSE ? 1'b0 : 1'b1;
            end else if (step_reg == 8'd6 + IR_LEN) begin
               // from pause walk exit2, update, idle
               tms_next = IR_PAUSE ? 1'b1 : 1'b0;
            end else if (step_reg == 8'd7 + IR_LEN) begin
               tms_next = 1'b1;
            end
            last = IR_PAUSE ? (step_reg == 8'd8 + IR_LEN) : (step_reg == 8'd6 + IR_LEN);
         end
         S_DRSEQ: begin
            // drsel, capture; bits shift on rises 3 to 2+N, then update, idle
            if (step_reg == 8'd0) begin
               tms_next = 1'b1;
            end else if (step_reg == 8'd2 + DR_LEN || step_reg == 8'd3 + DR_LEN) begin
               tms_next = 1'b1;
            end
            last = (step_reg == 8'd4 + DR_LEN);
         end
         default: begin
            tms_next = 1'b0;
         end
      endcase
   end

   // --------------------------------------------------
   // player sequencer
   // --------------------------------------------------
   always @(posedge clk_sys) begin
      if (!rstn) begin
         phase_reg                <= S_IDLE;
         busy_reg                 <= 1'b0;
         done_reg                 <= 1'b0;
         id_value_reg             <= {DR_LEN{1'b0}};
         tck_reg                  <= 1'b0;
         tms_reg                  <= 1'b1;
         tdi_reg                  <= 1'b1;
         div_reg                  <= 8'h00;
         step_reg                 <= 8'h00;
         wait_reg                 <= 16'h0000;
         tck_wait_reg             <= 4'h0;
         ir_sh_reg                <= {IR_LEN{1'b0}};
         dr_sh_reg                <= {DR_LEN{1'b0}};
         config_scheme_select_reg <= `CFG_SCHEME_JTAG_AS;
         chain_enable_n_reg       <= 1'b0;
      end else begin
         config_scheme_select_reg <= `CFG_SCHEME_JTAG_AS;
         chain_enable_n_reg       <= 1'b0;
         done_reg                 <= 1'b0;
         // free-running divider; tck toggles only while busy
         if (div_reg == HALF[7:0] - 8'd1) begin
            div_reg <= 8'h00;
            // done phase still lets the last high half finish
            if (busy_reg) begin
               tck_reg <= ~tck_reg;
            end
         end else begin
            div_reg <= div_reg + 8'd1;
         end
         // target drives tdo on fall; we sample it on the tck rise
         if (rise && phase_reg == S_DRSEQ && tap_state == `ST_DRSHIFT) begin
            dr_sh_reg <= {tdo_s2_reg, dr_sh_reg[DR_LEN-1:1]};
         end
         // drive new tms/tdi on the falling edge of tck, same clk_sys edge
         if (fall) begin
            tms_reg <= tms_next;
            if (phase_reg == S_IRSEQ && step_reg >= 8'd5) begin
               tdi_reg   <= ir_sh_reg[0];
               ir_sh_reg <= {1'b1, ir_sh_reg[IR_LEN-1:1]};
            end else begin
               tdi_reg <= 1'b1;
            end
         end
         if (rise) begin
            step_reg <= step_reg + 8'd1;
         end
         case (phase_reg)
            S_IDLE: begin
               if (start) begin
                  busy_reg  <= 1'b1;
                  phase_reg <= S_RST;
                  step_reg  <= 8'h00;
                  tms_reg   <= 1'b1;
                  ir_sh_reg <= `ID_SELECT_INSTR;
               end
            end
            S_RST: begin
               if (rise && last) begin
                  phase_reg <= S_IRSEQ;
                  step_reg  <= 8'h00;
               end
            end
            S_IRSEQ: begin
               if (rise && last) begin
                  phase_reg    <= S_WAIT;
                  step_reg     <= 8'h00;
                  wait_reg     <= 16'h0000;
                  tck_wait_reg <= 4'h0;
               end
            end
            S_WAIT: begin
               if (wait_reg != 16'hFFFF) begin
                  wait_reg <= wait_reg + 16'd1;
               end
               if (rise && tck_wait_reg != 4'hF) begin
                  tck_wait_reg <= tck_wait_reg + 4'd1;
               end
               if (rise && wait_reg >= WAIT_SYS[15:0] && tck_wait_reg >= `WAIT_MIN_CYCLES) begin
                  // this rise still idles; tms rises on the next fall
                  phase_reg <= S_DRSEQ;
                  step_reg  <= 8'h00;
               end
            end
            S_DRSEQ: begin
               if (rise && last) begin
                  phase_reg <= S_DONE;
               end
            end
            S_DONE: begin
               if (fall) begin
                  id_value_reg <= dr_sh_reg;
                  done_reg     <= 1'b1;
                  busy_reg     <= 1'b0;
                  phase_reg    <= S_IDLE;
               end
            end
            default: begin
               phase_reg <= S_IDLE;
            end
         endcase
      end
   end

endmodule // scan_player
`default_nettype wire

// ===== hdl/scan_player_consts.vh
// Purpose: constants for the host scan player
// Assumes: 40 MHz system clock
// Notes:   tap state codes follow the usual 4-bit ordering
`ifndef SCAN_PLAYER_CONSTS_VH
`define SCAN_PLAYER_CONSTS_VH

`define CLK_SYS_MHZ          40
`define TCK_HALF_CYCLES      4
`define RESET_TMS_EDGES      5
`define IR_LEN               10
`define DR_LEN               32
`define ID_SELECT_INSTR      10'h0_26
`define ONES_DATA            32'hFFFF_FFFF
`define WAIT_USEC            5
`define WAIT_MIN_CYCLES      3
`define WAIT_SYS_CYCLES      (`WAIT_USEC * `CLK_SYS_MHZ)
`define CFG_SCHEME_JTAG_AS   2'h0

`define ST_RESET             4'h0
`define ST_IDLE              4'h1
`define ST_DRSELECT          4'h2
`define ST_DRCAPTURE         4'h3
`define ST_DRSHIFT           4'h4
`define ST_DREXIT1           4'h5
`define ST_DRPAUSE           4'h6
`define ST_DREXIT2           4'h7
`define ST_DRUPDATE          4'h8
`define ST_IRSELECT          4'h9
`define ST_IRCAPTURE         4'hA
`define ST_IRSHIFT           4'hB
`define ST_IREXIT1           4'hC
`define ST_IRPAUSE           4'hD
`define ST_IREXIT2           4'hE
`define ST_IRUPDATE          4'hF

`endif

// ===== hdl/tap_state_tracker.v
// Purpose: mirror of the target's tap controller state
// Assumes: step pulses once per rising tck the player issues
// Notes:   lets the player know where the target stands
`timescale 1ns/1ps
`default_nettype none
`include "scan_player_consts.vh"

module tap_state_tracker (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rstn,
   // tck rise event
   input  wire       step,
   input  wire       tms,
   // state
   output reg  [3:0] state_reg
);

   reg [3:0] state_next;

   // ----------------------------------------
   // sixteen-state transition table
   // ----------------------------------------
   always @* begin
      case (state_reg)
         `ST_RESET:     state_next = tms ? `ST_RESET     : `ST_IDLE;
         `ST_IDLE:      state_next = tms ? `ST_DRSELECT  : `ST_IDLE;
         `ST_DRSELECT:  state_next = tms ? `ST_IRSELECT  : `ST_DRCAPTURE;
         `ST_DRCAPTURE: state_next = tms ? `ST_DREXIT1   : `ST_DRSHIFT;
         `ST_DRSHIFT:   state_next = tms ? `ST_DREXIT1   : `ST_DRSHIFT;
         `ST_DREXIT1:   state_next = tms ? `ST_DRUPDATE  : `ST_DRPAUSE;
         `ST_DRPAUSE:   state_next = tms ? `ST_DREXIT2   : `ST_DRPAUSE;
         `ST_DREXIT2:   state_next = tms ? `ST_DRUPDATE  : `ST_DRSHIFT;
         `ST_DRUPDATE:  state_next = tms ? `ST_DRSELECT  : `ST_IDLE;
         `ST_IRSELECT:  state_next = tms ? `ST_RESET     : `ST_IRCAPTURE;
         `ST_IRCAPTURE: state_next = tms ? `ST_IREXIT1   : `ST_IRSHIFT;
         `ST_IRSHIFT:   state_next = tms ? `ST_IREXIT1   : `ST_IRSHIFT;
         `ST_IREXIT1:   state_next = tms ? `ST_IRUPDATE  : `ST_IRPAUSE;
         `ST_IRPAUSE:   state_next = tms ? `ST_IREXIT2   : `ST_IRPAUSE;
         `ST_IREXIT2:   state_next = tms ? `ST_IRUPDATE  : `ST_IRSHIFT;
         `ST_IRUPDATE:  state_next = tms ? `ST_DRSELECT  : `ST_IDLE;
         default:       state_next = `ST_RESET;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= `ST_RESET;
      end else if (step) begin
         state_reg <= state_next;
      end
   end

endmodule // tap_state_tracker
`default_nettype wire

// ===== dv/scan_player_assertions.sv
// Purpose: port checks on the scan player
// Assumes: one clock domain, sync active-low reset
// Notes:   the tap walk itself is judged by the target model
`timescale 1ns/1ps
`default_nettype none
module scan_player_assertions #(
   parameter HALF = 4
) (
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       start,
   input wire logic       busy_reg,
   input wire logic       done_reg,
   input wire logic       tck_reg,
   input wire logic       tms_reg,
   input wire logic       tdi_reg,
   input wire logic [1:0] config_scheme_select_reg,
   input wire logic       chain_enable_n_reg
);
   logic       tck_q;
   logic [7:0] rise_cnt;
   logic [7:0] high_cnt;
   always_ff @(posedge clk_sys) begin
      tck_q <= tck_reg;
      if (!rstn || !busy_reg) rise_cnt <= 8'h00;
      else if (tck_reg && !tck_q && rise_cnt != 8'hFF) rise_cnt <= rise_cnt + 8'h01;
      if (!rstn || !tck_reg) high_cnt <= 8'h00;
      else high_cnt <= high_cnt + 8'h01;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   AST_SCHEME: assert property (config_scheme_select_reg == 2'h0)
      else $error("scheme select left 00");
   AST_CHAIN: assert property (!chain_enable_n_reg)
      else $error("chain enable not low");
   AST_RESET_WALK: assert property (tck_reg && !tck_q && rise_cnt < 8'h05 |-> tms_reg)
      else $error("mode select low in reset walk");
   AST_PINS_HOLD: assert property (tck_reg && $past(tck_reg) |-> $stable(tms_reg) && $stable(tdi_reg))
      else $error("scan pins moved while tck high");
   AST_TCK_HALF: assert property ($fell(tck_reg) |-> high_cnt == HALF)
      else $error("tck high phase wrong length");
   AST_IDLE_TCK: assert property (!busy_reg && !$past(busy_reg) |-> !tck_reg)
      else $error("tck runs outside a read");
   AST_START: assert property (start && !busy_reg |=> busy_reg)
      else $error("start not taken");
   AST_DONE_ONE: assert property (done_reg |=> !done_reg)
      else $error("done longer than one cycle");
   AST_DONE_END: assert property (done_reg && !start |=> !busy_reg)
      else $error("busy after done");
   cover property (done_reg);
   cover property (start && busy_reg);
   cover property (done_reg ##1 start);
endmodule // scan_player_assertions
bind scan_player scan_player_assertions #(.HALF(HALF)) i_chk (
   .clk_sys(clk_sys), .rstn(rstn), .start(start), .busy_reg(busy_reg), .done_reg(done_reg),
   .tck_reg(tck_reg), .tms_reg(tms_reg), .tdi_reg(tdi_reg),
   .config_scheme_select_reg(config_scheme_select_reg), .chain_enable_n_reg(chain_enable_n_reg));
`default_nettype wire

// ===== dv/target_tap_model.sv
// Purpose: behavioural target device behind the scan pins
// Assumes: state codes of the player's header
// Notes:   no serial boot modelled, so the scan port always wins
`timescale 1ns/1ps
`default_nettype none
`include "scan_player_consts.vh"
module target_tap_model (
   // scan pins
   input  wire logic        tck,
   input  wire logic        tms,
   input  wire logic        tdi,
   output logic             tdo,
   // identity and observations
   input  wire logic [31:0] id_word,
   output logic [9:0]       ir_val,
   output logic [7:0]       ir_n,
   output logic [31:0]      dr_in,
   output logic [7:0]       dr_n,
   output logic             wait_ok,
   output logic             paused
);
   logic [3:0]  st = `ST_IDLE;
   logic [9:0]  ir_sh;
   logic [31:0] dr_sh;
   logic [7:0]  cnt;
   logic [7:0]  idle_n;
   realtime     t0;
   // known level so the toggling idle line never stays unknown
   initial tdo = 1'b0;
   // ir leg codes sit 7 above the dr leg
   function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
      logic [3:0] o;
      o = (s >= 4'h9) ? 4'h7 : 4'h0;
      case (s - o)
         4'h0: nxt = m ? 4'h0 : 4'h1;
         4'h1: nxt = m ? 4'h2 : 4'h1;
         4'h2: nxt = m ? (o ? 4'h0 : 4'h9) : 4'h3 + o;
         4'h3, 4'h4: nxt = (m ? 4'h5 : 4'h4) + o;
         4'h5: nxt = (m ? 4'h8 : 4'h6) + o;
         4'h6: nxt = (m ? 4'h7 : 4'h6) + o;
         4'h7: nxt = (m ? 4'h8 : 4'h4) + o;
         default: nxt = m ? 4'h2 : 4'h1;
      endcase
   endfunction
   always @(posedge tck) begin
      st <= nxt(st, tms);
      case (st)
         `ST_IRCAPTURE: begin
            ir_sh <= 10'h001;
            cnt <= 8'h00;
            paused <= 1'b0;
         end
         `ST_IRSHIFT: begin
            ir_sh <= {tdi, ir_sh[9:1]};
            cnt <= cnt + 8'h01;
         end
         `ST_IRPAUSE: paused <= 1'b1;
         `ST_IRUPDATE: begin
            ir_val <= ir_sh;
            ir_n <= cnt;
            wait_ok <= 1'b0;
            t0 <= $realtime;
            idle_n <= 8'h00;
         end
         `ST_IDLE: begin
            idle_n <= idle_n + 8'h01;
            if (tms) wait_ok <= ($realtime - t0 >= 5000.0) && (idle_n >= 8'h03);
         end
         // other instructions read zeros, a cheap stand-in for bypass
         `ST_DRCAPTURE: begin
            dr_sh <= (ir_val == `ID_SELECT_INSTR) ? id_word : 32'h0000_0000;
            cnt <= 8'h00;
         end
         `ST_DRSHIFT: begin
            dr_sh <= {tdi, dr_sh[31:1]};
            cnt <= cnt + 8'h01;
         end
         `ST_DRUPDATE: begin
            dr_in <= dr_sh;
            dr_n <= cnt;
         end
         default: ;
      endcase
   end
   // outside shift the line toggles so a stale bit never looks valid
   always @(negedge tck)
      tdo <= (st == `ST_DRSHIFT) ? dr_sh[0] : (st == `ST_IRSHIFT) ? ir_sh[0] : ~tdo;
endmodule // target_tap_model
`default_nettype wire

// ===== dv/tb_jtag_tap_scan_sequencer.sv
// Purpose: identification reads against the target model
// Assumes: default tck divider and 5 us wait
// Notes:   random id words, corners first
`timescale 1ns/1ps
`default_nettype none
`include "scan_player_consts.vh"
module tb_jtag_tap_scan_sequencer;
   logic        clk_sys, rstn, start, tdo, busy_reg, done_reg;
   logic        tck_reg, tms_reg, tdi_reg, chain_enable_n_reg, wait_ok, paused;
   logic [1:0]  config_scheme_select_reg;
   logic [31:0] id_value_reg, id_word, dr_in;
   logic [9:0]  ir_val;
   logic [7:0]  ir_n, dr_n;
   int          errors, comparisons, cycles, dones;
   scan_player i_dut (.clk_sys(clk_sys), .rstn(rstn), .start(start), .busy_reg(busy_reg),
      .done_reg(done_reg), .id_value_reg(id_value_reg), .tck_reg(tck_reg), .tms_reg(tms_reg),
      .tdi_reg(tdi_reg), .tdo(tdo), .config_scheme_select_reg(config_scheme_select_reg),
      .chain_enable_n_reg(chain_enable_n_reg));
   target_tap_model i_tgt (.tck(tck_reg), .tms(tms_reg), .tdi(tdi_reg), .tdo(tdo), .id_word(id_word),
      .ir_val(ir_val), .ir_n(ir_n), .dr_in(dr_in), .dr_n(dr_n), .wait_ok(wait_ok), .paused(paused));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (done_reg === 1'b1) dones++;
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic step();
      @(posedge clk_sys);
      #2;
   endtask
   // poke raises start again mid-read, which must be ignored
   task automatic run(input logic poke);
      int n;
      n = 0;
      start = 1'b1;
      step();
      start = 1'b0;
      while (done_reg !== 1'b1 && n < 5000) begin
         start = poke && n == 300;
         step();
         n++;
      end
      chk("done", 32'h0000_0001, done_reg);
      chk("id", id_word, id_value_reg);
      chk("ir word", `ID_SELECT_INSTR, ir_val);
      chk("ir bits", `IR_LEN, ir_n);
      chk("dr in", `ONES_DATA, dr_in);
      chk("dr bits", `DR_LEN, dr_n);
      chk("idle wait", 32'h0000_0001, wait_ok);
      chk("ir pause", 32'h0000_0001, paused);
      chk("scheme", 32'h0000_0000, config_scheme_select_reg);
      chk("chain en", 32'h0000_0000, chain_enable_n_reg);
   endtask
   initial begin
      errors = 0;
      comparisons = 0;
      cycles = 0;
      dones = 0;
      rstn = 1'b0;
      start = 1'b0;
      id_word = 32'h0000_0000;
      void'($urandom(32'h70f0_4374));
      repeat (3) step();
      rstn = 1'b1;
      for (int i = 0; i < 5; i++) begin
         id_word = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
         run(i == 2);
         if (i != 3) repeat ($urandom_range(20, 0)) step();
      end
      chk("reads", 32'h0000_0005, dones);
      start = 1'b1;
      step();
      start = 1'b0;
      repeat ($urandom_range(400, 40)) step();
      rstn = 1'b0;
      repeat (2) step();
      chk("reset pins", 32'h0000_0003, {busy_reg, done_reg, tck_reg, tms_reg, tdi_reg});
      chk("reset id", 32'h0000_0000, id_value_reg);
      rstn = 1'b1;
      id_word = $urandom;
      run(1'b0);
      conclude();
   end
endmodule // tb_jtag_tap_scan_sequencer
`default_nettype wire
